// ---- design/pmev_defs.svh ----
// Constants for the power-management event status and enable block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef PMEV_DEFS_SVH
`define PMEV_DEFS_SVH

// Register offsets from the programmable I/O base
`define PMEV_OFS_STS1 16'h0000
`define PMEV_OFS_STS2 16'h0001
`define PMEV_OFS_EN1 16'h0002

// Field positions
`define PMEV_BIT_TMR 0
`define PMEV_BIT_BM 4
`define PMEV_BIT_GBL 5
`define PMEV_BIT_WAK 7

// Reset values
`define PMEV_RST_BYTE 8'h00
`define PMEV_RST_BASE 16'h0000

// Timer
`define PMEV_TMR_WIDTH 24
`define PMEV_TMR_CLK_HZ 3579545
`define PMEV_MCLK_HZ 25000000

`endif

// ---- design/pmev_pkg.sv ----
// Types shared by the power-management event block.
// Assumes nothing of its surroundings.
package pmev_pkg;

   // Sleeping/working system state
   typedef enum logic {
      PMEV_WORKING,
      PMEV_SLEEPING
   } pmev_state_t;

   typedef logic [7:0] pmev_byte_t;

endpackage

// ---- design/pmev_pm_timer.sv ----
// Free-running power-management counter and its top-bit toggle detector.
// Assumes the timer clock pin is slower than half of i_mclk.
`timescale 1ns/100ps
`include "pmev_defs.svh"
module pmev_pm_timer import pmev_pkg::*; #(
   parameter int WIDTH = `PMEV_TMR_WIDTH
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Timer clock pin and run enable
   input wire logic i_tick_clk,
   input wire logic i_run,
   // Counter value and top-bit change
   output logic [WIDTH-1:0] o_count,
   output logic o_msb_toggle
);

   initial begin
      if (WIDTH < 2) begin
         $error("pmev_pm_timer: WIDTH must be at least 2");
      end
   end

   logic tick_meta;
   logic tick_sync;
   logic tick_last;
   logic msb_last;
   logic [WIDTH-1:0] count;

   // Rising edge of the slow clock; first stage is read by the second only
   wire tick_rise = tick_sync & ~tick_last;
   wire [WIDTH-1:0] next_count = tick_rise && i_run ? count + 1'b1 : count;  // see RULE_16

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tick_meta <= 1'b0;
         tick_sync <= 1'b0;
         tick_last <= 1'b0;
      end else begin
         tick_meta <= i_tick_clk;
         tick_sync <= tick_meta;
         tick_last <= tick_sync;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count <= '0;
         msb_last <= 1'b0;
         o_msb_toggle <= 1'b0;
      end else begin
         count <= next_count;
         msb_last <= count[WIDTH-1];
         o_msb_toggle <= count[WIDTH-1] ^ msb_last;  // see RULE_01
      end
   end

   assign o_count = count;

   counter_step_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_16
      (tick_rise && i_run) |=> (count == $past(count) + 1'b1))
      else $error("counter did not advance on a timer tick");

endmodule

// ---- design/pmev_regs.sv ----
// Power-management status one/two and enable one registers, with the
// sleeping/working state machine and interrupt routing.
// Assumes I/O strobes are one-cycle pulses synchronous to i_mclk and the
// control-block bits arrive as same-domain pulses and levels.
//
// Notes on behaviour
// (RULE_01) Timer top bit change sets timer carry status
// (RULE_02) Carry status and enable raise power event
// (RULE_03) Carry status hardware-set, write one clears
// (RULE_04) Bus master control set also sets status
// (RULE_05) Write one clears bus master status, control
// (RULE_06) Firmware release sets global status
// (RULE_07) Write one clears global status and release
// (RULE_08) Enabled resume while sleeping sets wake status
// (RULE_09) Wake status moves system to working
// (RULE_10) Wake clears by write one or standby expiry
// (RULE_11) Wake clear, all asleep: chip sleeps
// (RULE_12) Timer enable gates carry status onto SCI
// (RULE_13) Global enable and status raise SCI
// (RULE_14) Enable bits one to four read zero
// (RULE_15) Status one bits six, seven read zero
// (RULE_16) Counter: 24-bit free-running up-count
// (RULE_17) Write one to release sets it, status
// (RULE_18) Route events to SCI, else SMI
// (RULE_19) SCI level while enabled pair remains set
`timescale 1ns/100ps
`include "pmev_defs.svh"
module pmev_regs import pmev_pkg::*; #(
   parameter int TMR_WIDTH = `PMEV_TMR_WIDTH
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // I/O space access
   input wire logic [15:0] i_io_base,
   input wire logic [15:0] i_io_addr,
   input wire logic i_io_wr,
   input wire logic i_io_rd,
   input wire logic [7:0] i_io_wdata,
   output logic [7:0] o_io_rdata,
   output logic o_io_rvalid,
   // Control-block bits kept elsewhere
   input wire logic i_bm_control_set,
   input wire logic i_fw_release_set,
   input wire logic i_sci_route_enable,
   input wire logic i_smi_route_enable,
   input wire logic i_timer_on,
   // Pins and system events
   input wire logic i_pm_timer_clk,
   input wire logic i_resume_event,
   input wire logic i_devices_asleep,
   input wire logic i_standby_expired,
   // Status outputs
   output logic o_bus_master_control,
   output logic o_firmware_release,
   output logic [TMR_WIDTH-1:0] o_pm_count,
   output logic o_pm_event,
   output logic o_sci,
   output logic o_smi,
   output logic o_chip_sleep
);

   // Narrower counters only shorten the wait for a carry in tests
   initial begin
      if (TMR_WIDTH < 2) begin
         $error("pmev_regs: timer width must be at least 2");
      end
   end

   // Stored bits
   logic timer_carry_status;
   logic bus_master_status;
   logic global_status;
   logic wake_status;
   logic timer_carry_enable;
   logic global_enable;
   logic bus_master_control;
   logic firmware_release;
   pmev_state_t state;
   pmev_state_t next_state;

   // Pin synchronisers
   logic resume_meta;
   logic resume_sync;
   logic asleep_meta;
   logic asleep_sync;

   logic [TMR_WIDTH-1:0] count;
   logic msb_toggle;

   pmev_pm_timer #(
      .WIDTH(TMR_WIDTH)
   ) u_timer (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_tick_clk(i_pm_timer_clk),
      .i_run(i_timer_on),
      .o_count(count),
      .o_msb_toggle(msb_toggle)
   );

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         resume_meta <= 1'b0;
         resume_sync <= 1'b0;
         asleep_meta <= 1'b0;
         asleep_sync <= 1'b0;
      end else begin
         resume_meta <= i_resume_event;
         resume_sync <= resume_meta;
         asleep_meta <= i_devices_asleep;
         asleep_sync <= asleep_meta;
      end
   end

   // Address decode
   wire [15:0] addr_sts1 = 16'(i_io_base + `PMEV_OFS_STS1);
   wire [15:0] addr_sts2 = 16'(i_io_base + `PMEV_OFS_STS2);
   wire [15:0] addr_en1 = 16'(i_io_base + `PMEV_OFS_EN1);
   wire hit_sts1 = i_io_addr == addr_sts1;
   wire hit_sts2 = i_io_addr == addr_sts2;
   wire hit_en1 = i_io_addr == addr_en1;
   wire wr_sts1 = i_io_wr & hit_sts1;
   wire wr_sts2 = i_io_wr & hit_sts2;
   wire wr_en1 = i_io_wr & hit_en1;
   wire any_hit = hit_sts1 | hit_sts2 | hit_en1;

   // Write-one-to-clear strobes
   wire clr_tmr = wr_sts1 & i_io_wdata[`PMEV_BIT_TMR];
   wire clr_bm = wr_sts1 & i_io_wdata[`PMEV_BIT_BM];
   wire clr_gbl = wr_sts1 & i_io_wdata[`PMEV_BIT_GBL];
   wire clr_wak = wr_sts2 & i_io_wdata[`PMEV_BIT_WAK];

   // Resume only counts while asleep
   wire wake_set = (state == PMEV_SLEEPING) & resume_sync;  // see RULE_08

   // Set wins over clear on every hardware-set flag
   wire next_timer_carry_status = msb_toggle | (timer_carry_status & ~clr_tmr);  // see RULE_01, RULE_03
   wire next_bus_master_status = i_bm_control_set | (bus_master_status & ~clr_bm);  // see RULE_04, RULE_05
   wire next_bm_ctl = i_bm_control_set | (bus_master_control & ~clr_bm);  // see RULE_05
   wire next_global_status = i_fw_release_set | (global_status & ~clr_gbl);  // see RULE_06, RULE_07
   wire next_fw_rls = i_fw_release_set | (firmware_release & ~clr_gbl);  // see RULE_07, RULE_17
   wire wake_clr = clr_wak | i_standby_expired;  // see RULE_10
   wire next_wake_status = wake_set | (wake_status & ~wake_clr);

   wire next_timer_carry_enable = wr_en1 ? i_io_wdata[`PMEV_BIT_TMR] : timer_carry_enable;
   wire next_global_enable = wr_en1 ? i_io_wdata[`PMEV_BIT_GBL] : global_enable;

   // Event and routing
   wire tmr_pair = timer_carry_status & timer_carry_enable;  // see RULE_02, RULE_12
   wire gbl_pair = global_status & global_enable;  // see RULE_13
   wire pm_event = tmr_pair | gbl_pair;
   wire next_sci = pm_event & i_sci_route_enable;  // see RULE_18, RULE_19
   wire next_smi = pm_event & ~i_sci_route_enable & i_smi_route_enable;  // see RULE_18

   // Sleeping/working machine
   always_comb begin
      next_state = state;
      unique case (state)
         PMEV_WORKING: begin
            if (!wake_status && asleep_sync) begin
               next_state = PMEV_SLEEPING;  // see RULE_11
            end
         end
         PMEV_SLEEPING: begin
            if (wake_status) begin
               next_state = PMEV_WORKING;  // see RULE_09
            end
         end
      endcase
   end

   // Read data; unused bits read zero
   wire [7:0] rd_sts1 = {2'b00, global_status, bus_master_status, 3'b000,
      timer_carry_status};  // see RULE_15
   wire [7:0] rd_sts2 = {wake_status, 7'h00};
   wire [7:0] rd_en1 = {2'b00, global_enable, 4'h0, timer_carry_enable};  // see RULE_14
   wire [7:0] rd_mux = hit_sts1 ? rd_sts1 : hit_sts2 ? rd_sts2 : hit_en1 ? rd_en1 :
      `PMEV_RST_BYTE;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         timer_carry_status <= 1'b0;
         bus_master_status <= 1'b0;
         global_status <= 1'b0;
         wake_status <= 1'b0;
         bus_master_control <= 1'b0;
         firmware_release <= 1'b0;
      end else begin
         timer_carry_status <= next_timer_carry_status;
         bus_master_status <= next_bus_master_status;
         global_status <= next_global_status;
         wake_status <= next_wake_status;
         bus_master_control <= next_bm_ctl;
         firmware_release <= next_fw_rls;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         timer_carry_enable <= 1'b0;
         global_enable <= 1'b0;
         state <= PMEV_WORKING;
      end else begin
         timer_carry_enable <= next_timer_carry_enable;
         global_enable <= next_global_enable;
         state <= next_state;
      end
   end

   // Outputs all registered; all but o_chip_sleep, taken from next_state, trail the stored bits by one cycle
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_io_rdata <= `PMEV_RST_BYTE;
         o_io_rvalid <= 1'b0;
         o_pm_event <= 1'b0;
         o_sci <= 1'b0;
         o_smi <= 1'b0;
         o_chip_sleep <= 1'b0;
         o_bus_master_control <= 1'b0;
         o_firmware_release <= 1'b0;
         o_pm_count <= '0;
      end else begin
         o_io_rdata <= i_io_rd ? rd_mux : `PMEV_RST_BYTE;
         o_io_rvalid <= i_io_rd & any_hit;
         o_pm_event <= pm_event;
         o_sci <= next_sci;
         o_smi <= next_smi;
         o_chip_sleep <= next_state == PMEV_SLEEPING;
         o_bus_master_control <= bus_master_control;
         o_firmware_release <= firmware_release;
         o_pm_count <= count;
      end
   end

   // Checks
   carry_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_01
      msb_toggle |=> timer_carry_status)
      else $error("carry status missed a top-bit change");

   carry_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_03
      (timer_carry_status && !clr_tmr && !msb_toggle) |=> timer_carry_status)
      else $error("carry status lost without a write of one");

   carry_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_03
      (clr_tmr && !msb_toggle) |=> !timer_carry_status)
      else $error("carry status not cleared by write of one");

   carry_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_03
      (!msb_toggle && !timer_carry_status) |=> !timer_carry_status)
      else $error("carry status set without a top-bit change");

   bm_link_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_04
      i_bm_control_set |=> (bus_master_status && bus_master_control))
      else $error("bus master control did not set status");

   bm_mirror_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_04
      i_bm_control_set |-> ##2 o_bus_master_control)
      else $error("bus master control not shown on its output");

   bm_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_05
      (clr_bm && !i_bm_control_set) |=> (!bus_master_status && !bus_master_control))
      else $error("bus master clear incomplete");

   gbl_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_06
      i_fw_release_set |=> (global_status && firmware_release))
      else $error("firmware release did not set global status");

   release_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_17
      i_fw_release_set |-> ##2 o_firmware_release)
      else $error("firmware release not shown on its output");

   gbl_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_07
      (clr_gbl && !i_fw_release_set) |=> (!global_status && !firmware_release))
      else $error("global status clear incomplete");

   wake_entry_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_08
      wake_set |=> wake_status)
      else $error("resume while sleeping did not set wake status");

   wake_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_09
      (state == PMEV_SLEEPING && resume_sync) |=> wake_status ##1 state == PMEV_WORKING)
      else $error("resume did not wake the system");

   wake_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_10
      (i_standby_expired && !wake_set) |=> !wake_status)
      else $error("standby expiry did not clear wake status");

   wake_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_10
      (wake_status && !wake_clr) |=> wake_status)
      else $error("wake status lost without a clear");

   sleep_entry_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_11
      (state == PMEV_WORKING && !wake_status && asleep_sync) |=> o_chip_sleep)
      else $error("chip did not enter sleeping state");

   awake_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_11
      (state == PMEV_WORKING && wake_status) |=> (state == PMEV_WORKING))
      else $error("chip slept while wake status was set");

   // Output-side checks trail the stored bits by one edge
   event_pair_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_02
      tmr_pair |=> o_pm_event)
      else $error("timer pair did not raise a power event");

   event_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_02
      (!tmr_pair && !gbl_pair) |=> !o_pm_event)
      else $error("power event with no enabled pair");

   sci_level_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_12
      (tmr_pair && i_sci_route_enable) |=> o_sci)
      else $error("timer pair did not raise SCI");

   tmr_mask_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_12
      (!timer_carry_enable && !gbl_pair) |=> !o_sci)
      else $error("SCI raised with timer carry disabled");

   gbl_sci_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_13
      (gbl_pair && i_sci_route_enable) |=> (o_sci && !o_smi))
      else $error("global pair did not raise SCI");

   sci_drop_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_19
      (!tmr_pair && !gbl_pair) |=> (!o_sci && !o_smi))
      else $error("interrupt stayed high with no enabled pair");

   smi_route_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_18
      (gbl_pair && !i_sci_route_enable && i_smi_route_enable) |=> (o_smi && !o_sci))
      else $error("event not routed to SMI");

   smi_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_18
      i_sci_route_enable |=> !o_smi)
      else $error("SMI raised while SCI routing enabled");

   en_readback_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_14
      (i_io_rd && hit_en1) |=> (o_io_rdata[4:1] == 4'h0))
      else $error("unused enable bits read nonzero");

   sts_readback_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // see RULE_15
      (i_io_rd && hit_sts1) |=> (o_io_rdata[7:6] == 2'h0))
      else $error("reserved status bits read nonzero");

endmodule

// ---- design/pmev_pkg_end.sv ----
// Empty marker not used.

// ---- bench/test_pmev_regs.sv ----
// Self-checking bench for the power-management event register block.
// Assumes the block alone; the bench drives every port itself.
`timescale 1ns/100ps
module test_pmev_regs;
   import pmev_pkg::*;
   localparam int TW = 4;
   localparam logic [15:0] BASE = 16'h0480;
   localparam int LIMIT = 6000;
   logic mclk = 1'b0, rst_n = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic wr = 1'b0, rd = 1'b0, bm_set = 1'b0, fw_set = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic rvalid, bm_ctl, fw_rel, pm_event, sci, smi, chip_sleep;
   logic sci_route = 1'b1, smi_route = 1'b0, timer_on = 1'b0, tclk = 1'b0;
   logic resume = 1'b0, asleep = 1'b0, standby = 1'b0, tick_en = 1'b0;
   logic [TW-1:0] count;
   int error_cnt = 0, checked = 0, cycles = 0, tdiv = 0, k, n;

   pmev_regs #(.TMR_WIDTH(TW)) DUT (
      .i_mclk(mclk), .i_rst_n(rst_n), .i_io_base(BASE), .i_io_addr(addr),
      .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wdata), .o_io_rdata(rdata),
      .o_io_rvalid(rvalid), .i_bm_control_set(bm_set), .i_fw_release_set(fw_set),
      .i_sci_route_enable(sci_route), .i_smi_route_enable(smi_route),
      .i_timer_on(timer_on), .i_pm_timer_clk(tclk), .i_resume_event(resume),
      .i_devices_asleep(asleep), .i_standby_expired(standby),
      .o_bus_master_control(bm_ctl), .o_firmware_release(fw_rel), .o_pm_count(count),
      .o_pm_event(pm_event), .o_sci(sci), .o_smi(smi), .o_chip_sleep(chip_sleep));

   initial begin
      forever #20 mclk = ~mclk;
   end

   // Timer pin: 7 cycles a period, near the 3.58 MHz rate; low while parked
   always @(posedge mclk) begin
      tdiv <= (!tick_en || tdiv == 6) ? 0 : tdiv + 1;
      tclk <= tick_en && (tdiv < 3);
   end

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         error_cnt++;
         end_of_test();
      end
   end

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic settle(input int c);
      repeat (c) @(posedge mclk);
      #1;
   endtask

   task automatic io_wr(input logic [15:0] ofs, input logic [7:0] d);
      @(posedge mclk);
      addr <= BASE + ofs;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   // Read data stands for one cycle only, so it is sampled right after it lands
   task automatic io_rd(input logic [15:0] ofs, input logic [7:0] exp, input logic vld);
      @(posedge mclk);
      addr <= BASE + ofs;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
      chk(rvalid, vld);
   endtask

   initial begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      settle(1);
      io_rd(0, 8'h00, 1);
      io_rd(1, 8'h00, 1);
      io_rd(2, 8'h00, 1);
      io_rd(3, 8'h00, 0);
      io_wr(3, 8'hff);
      io_wr(2, 8'hff);
      io_rd(2, 8'h21, 1);
      io_wr(2, 8'h00);
      $display("test reset_map done");

      @(posedge mclk) fw_set <= 1'b1;
      @(posedge mclk) fw_set <= 1'b0;
      settle(2);
      chk(fw_rel, 1);
      io_rd(0, 8'h20, 1);
      chk(sci, 0);
      io_wr(2, 8'h20);
      settle(2);
      chk(sci, 1);
      @(posedge mclk) sci_route <= 1'b0;
      smi_route <= 1'b1;
      settle(3);
      chk({sci, smi}, 2'b01);
      @(posedge mclk) smi_route <= 1'b0;
      settle(3);
      chk(smi, 0);
      @(posedge mclk) sci_route <= 1'b1;
      io_wr(0, 8'hdf);
      io_rd(0, 8'h20, 1);
      io_wr(0, 8'h20);
      settle(2);
      chk({fw_rel, sci}, 2'b00);
      io_rd(0, 8'h00, 1);
      io_wr(2, 8'h00);
      $display("test global done");

      @(posedge mclk) bm_set <= 1'b1;
      @(posedge mclk) bm_set <= 1'b0;
      settle(2);
      chk(bm_ctl, 1);
      io_rd(0, 8'h10, 1);
      io_wr(0, 8'h00);
      io_rd(0, 8'h10, 1);
      io_wr(0, 8'h10);
      settle(2);
      chk(bm_ctl, 0);
      io_rd(0, 8'h00, 1);
      $display("test bus_master done");

      // Counter must hold while switched off even with the pin running
      @(posedge mclk) tick_en <= 1'b1;
      settle(30);
      chk(count, 0);
      @(posedge mclk) tick_en <= 1'b0;
      timer_on <= 1'b1;
      // First pass: top bit rises; second pass: wrap makes it fall
      for (k = 0; k < 2; k++) begin
         @(posedge mclk) tick_en <= 1'b1;
         n = 0;
         // Count is looked at once it has settled after each edge
         while (count !== (k == 0 ? 4'h8 : 4'h0) && n < 200) begin
            @(posedge mclk);
            #1;
            n++;
         end
         @(posedge mclk) tick_en <= 1'b0;
         settle(8);
         chk(count, k == 0 ? 4'h8 : 4'h0);
         io_rd(0, 8'h01, 1);
         chk(sci, k[0]);
         if (k == 0) begin
            chk(pm_event, 0);
            io_wr(2, 8'h01);
            settle(2);
            chk({sci, pm_event}, 2'b11);
            io_wr(0, 8'h00);
            io_rd(0, 8'h01, 1);
         end
         io_wr(0, 8'h01);
         settle(2);
         chk({sci, pm_event}, 2'b00);
         io_rd(0, 8'h00, 1);
      end
      $display("test timer done");

      @(posedge mclk) resume <= 1'b1;
      settle(8);
      io_rd(1, 8'h00, 1);
      @(posedge mclk) resume <= 1'b0;
      asleep <= 1'b1;
      settle(8);
      chk(chip_sleep, 1);
      @(posedge mclk) resume <= 1'b1;
      settle(8);
      io_rd(1, 8'h80, 1);
      chk(chip_sleep, 0);
      io_wr(1, 8'h7f);
      io_rd(1, 8'h80, 1);
      @(posedge mclk) resume <= 1'b0;
      settle(4);
      io_wr(1, 8'h80);
      settle(8);
      io_rd(1, 8'h00, 1);
      chk(chip_sleep, 1);
      @(posedge mclk) resume <= 1'b1;
      settle(8);
      io_rd(1, 8'h80, 1);
      @(posedge mclk) resume <= 1'b0;
      settle(4);
      @(posedge mclk) standby <= 1'b1;
      @(posedge mclk) standby <= 1'b0;
      settle(8);
      io_rd(1, 8'h00, 1);
      chk(chip_sleep, 1);
      $display("test wake done");
      end_of_test();
   end
endmodule
